/* File: adcc_pkg.sv */
// Purpose: shared constants and types of the converter control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   all counts are in converter-clock ticks unless named otherwise
package adcc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_MAIN   = 8'h00;
    localparam logic [7:0] ADDR_ACC    = 8'h01;
    localparam logic [7:0] ADDR_REFCLK = 8'h02;
    localparam logic [7:0] ADDR_DELAY  = 8'h03;
    localparam logic [7:0] ADDR_WIN    = 8'h04;
    localparam logic [7:0] ADDR_SAMP   = 8'h05;
    localparam logic [7:0] ADDR_CMD    = 8'h08;
    localparam logic [7:0] ADDR_FLAGS  = 8'h0B;
    localparam logic [7:0] ADDR_RES_LO = 8'h10;
    localparam logic [7:0] ADDR_RES_HI = 8'h11;
    localparam logic [7:0] ADDR_WLT_LO = 8'h12;
    localparam logic [7:0] ADDR_WLT_HI = 8'h13;
    localparam logic [7:0] ADDR_WHT_LO = 8'h14;
    localparam logic [7:0] ADDR_WHT_HI = 8'h15;
    // Reset value and writable-bit masks
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [7:0] MASK_MAIN   = 8'h87;
    localparam logic [7:0] MASK_ACC    = 8'h07;
    localparam logic [7:0] MASK_REFCLK = 8'h77;
    localparam logic [7:0] MASK_WIN    = 8'h07;
    localparam logic [7:0] MASK_SAMP   = 8'h1F;
    // Field positions
    localparam int BIT_EN   = 0;
    localparam int BIT_FREE = 1;
    localparam int BIT_RES  = 2;
    localparam int BIT_STBY = 7;
    localparam int BIT_CAP  = 6;
    localparam int BIT_SAMPLE_DELAY_VARY = 4;
    localparam int BIT_RDY  = 0;
    localparam int BIT_WIN  = 1;
    // Field codes
    localparam logic [2:0] ACC_MAX     = 3'h6;
    localparam logic [2:0] INIT_MAX    = 3'h5;
    localparam logic [1:0] REF_INT     = 2'h0;
    localparam logic [1:0] REF_MAX     = 2'h2;
    localparam logic [2:0] WIN_NONE    = 3'h0;
    localparam logic [2:0] WIN_BELOW   = 3'h1;
    localparam logic [2:0] WIN_ABOVE   = 3'h2;
    localparam logic [2:0] WIN_INSIDE  = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;
    // Counts: start-up delay is 16 << (code-1) = 8 << code ticks
    localparam logic [8:0] INIT_BASE   = 9'h008;
    localparam logic [5:0] SAMP_BASE   = 6'h02;
    localparam logic [9:0] CONV_MAX    = 10'h3FF;
    localparam logic [15:0] ACC_LIMIT  = 16'hFFC0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INIT,
        ST_SAMPLE,
        ST_CONVERT,
        ST_GAP
    } adcc_state_t;
endpackage

/* File: adcc_top.sv */
// Purpose: control sequencer and registers of a 10-bit successive-approximation converter
// Assumes: standby_sleep, deep_wake and the core run on mclk; core_done is a pulse
// Notes:   converter clock is a one-cycle tick from a divider of mclk
module adcc_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Power state
    input  wire logic        standby_sleep,
    input  wire logic        deep_wake,
    // Analog core
    input  wire logic        core_done,
    input  wire logic [9:0]  core_result,
    output logic             core_enable,
    output logic             sample_switch_closed,
    output logic             convert_start,
    output logic      [1:0]  reference_select,
    output logic             sample_cap_select
);
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    logic [7:0]  main_ff, acc_ctl_ff, refclk_ff, delay_ff, win_ff, samp_ff;
    logic [15:0] wlt_ff, wht_ff, result_ff, acc_ff, nxt_acc;
    logic        rdy_ff, winf_ff, busy_ff, init_pend_ff, en_d_ff, convert_start_ff;
    logic [7:0]  div_cnt_ff, rdata_ff, div_last;
    logic [8:0]  div_full, init_cyc, cnt_ff;
    logic [6:0]  n_samp, idx_ff;
    logic [5:0]  samp_len;
    logic [9:0]  samp_val;
    adcc_pkg::adcc_state_t state_ff;
    logic        wr_main, wr_acc, wr_refclk, wr_delay, wr_win, wr_samp, wr_cmd, wr_flags;
    logic        wr_wlt_lo, wr_wlt_hi, wr_wht_lo, wr_wht_hi;
    logic        running, tick, start_req, smp_done, conv_last, win_hit, rdy_clr, win_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    always_comb begin
        wr_main = 1'b0; wr_acc = 1'b0; wr_refclk = 1'b0; wr_delay = 1'b0;
        wr_win = 1'b0; wr_samp = 1'b0; wr_cmd = 1'b0; wr_flags = 1'b0;
        wr_wlt_lo = 1'b0; wr_wlt_hi = 1'b0; wr_wht_lo = 1'b0; wr_wht_hi = 1'b0;
        if (!reg_wr) begin
            wr_main = 1'b0;
        end else if (reg_addr == adcc_pkg::ADDR_MAIN) begin
            wr_main = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_ACC) begin
            wr_acc = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_REFCLK) begin
            wr_refclk = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_DELAY) begin
            wr_delay = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_WIN) begin
            wr_win = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_SAMP) begin
            wr_samp = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_CMD) begin
            wr_cmd = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_FLAGS) begin
            wr_flags = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_WLT_LO) begin
            wr_wlt_lo = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_WLT_HI) begin
            wr_wlt_hi = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_WHT_LO) begin
            wr_wht_lo = 1'b1;
        end else if (reg_addr == adcc_pkg::ADDR_WHT_HI) begin
            wr_wht_hi = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            main_ff    <= adcc_pkg::REG_RST;
            acc_ctl_ff <= adcc_pkg::REG_RST;
            refclk_ff  <= adcc_pkg::REG_RST;
            win_ff     <= adcc_pkg::REG_RST;
            samp_ff    <= adcc_pkg::REG_RST;
        end else begin
            if (wr_main) main_ff <= reg_wdata & adcc_pkg::MASK_MAIN;
            if (wr_acc) acc_ctl_ff <= reg_wdata & adcc_pkg::MASK_ACC;
            if (wr_refclk) refclk_ff <= reg_wdata & adcc_pkg::MASK_REFCLK;
            if (wr_win) win_ff <= reg_wdata & adcc_pkg::MASK_WIN;
            if (wr_samp) samp_ff <= reg_wdata & adcc_pkg::MASK_SAMP;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wlt_ff <= 16'h0000;
            wht_ff <= 16'h0000;
        end else begin
            if (wr_wlt_lo) wlt_ff[7:0] <= reg_wdata;
            if (wr_wlt_hi) wlt_ff[15:8] <= reg_wdata;
            if (wr_wht_lo) wht_ff[7:0] <= reg_wdata;
            if (wr_wht_hi) wht_ff[15:8] <= reg_wdata;
        end
    end

    // Software write wins over the automatic step so a new base value is never lost
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            delay_ff <= adcc_pkg::REG_RST;
        end else if (wr_delay) begin
            delay_ff <= reg_wdata;
        end else if (smp_done && delay_ff[adcc_pkg::BIT_SAMPLE_DELAY_VARY]) begin
            delay_ff[3:0] <= delay_ff[3:0] + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run gating
    assign running = main_ff[adcc_pkg::BIT_EN]
                     && (!standby_sleep || main_ff[adcc_pkg::BIT_STBY]);
    assign core_enable = running;
    assign reference_select = (refclk_ff[5:4] > adcc_pkg::REF_MAX) ? adcc_pkg::REF_INT
                                                                   : refclk_ff[5:4];
    assign sample_cap_select = refclk_ff[adcc_pkg::BIT_CAP];

    // divider, compare with >= so a smaller code mid-count cannot stall the tick
    assign div_full = 9'(9'h002 << refclk_ff[2:0]);
    assign div_last = 8'(div_full - 9'h001);
    assign tick     = running && (div_cnt_ff >= div_last);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_ff <= 8'h00;
        end else if (!running || tick) begin
            div_cnt_ff <= 8'h00;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up length
    assign init_cyc = (delay_ff[7:5] == 3'h0 || delay_ff[7:5] > adcc_pkg::INIT_MAX) ? 9'h000
                      : 9'(adcc_pkg::INIT_BASE << delay_ff[7:5]);
    assign n_samp = (acc_ctl_ff[2:0] > adcc_pkg::ACC_MAX) ? 7'h01
                    : 7'(7'h01 << acc_ctl_ff[2:0]);
    assign samp_len = adcc_pkg::SAMP_BASE + {1'b0, samp_ff[4:0]};
    assign samp_val = main_ff[adcc_pkg::BIT_RES] ? {2'h0, core_result[9:2]}
                      : ((core_result > adcc_pkg::CONV_MAX) ? adcc_pkg::CONV_MAX : core_result);
    assign nxt_acc  = acc_ff + {6'h00, samp_val};

    assign start_req = wr_cmd && reg_wdata[0] && main_ff[adcc_pkg::BIT_EN]
                       && state_ff == adcc_pkg::ST_IDLE;
    assign smp_done  = running && core_done && state_ff == adcc_pkg::ST_CONVERT;
    assign conv_last = smp_done && (idx_ff == n_samp - 7'h01);

    // Start-up delay owed after enable, switch to internal reference or deep wake
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            en_d_ff      <= 1'b0;
            init_pend_ff <= 1'b0;
        end else begin
            en_d_ff <= main_ff[adcc_pkg::BIT_EN];
            if ((main_ff[adcc_pkg::BIT_EN] && !en_d_ff) || deep_wake
                || (wr_refclk && reg_wdata[5:4] == adcc_pkg::REF_INT
                    && refclk_ff[5:4] != adcc_pkg::REF_INT)) begin
                init_pend_ff <= 1'b1;
            end else if (state_ff == adcc_pkg::ST_INIT) begin
                init_pend_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff         <= adcc_pkg::ST_IDLE;
            cnt_ff           <= 9'h000;
            idx_ff           <= 7'h00;
            acc_ff           <= 16'h0000;
            busy_ff          <= 1'b0;
            convert_start_ff <= 1'b0;
        end else if (!main_ff[adcc_pkg::BIT_EN]) begin
            state_ff         <= adcc_pkg::ST_IDLE;
            busy_ff          <= 1'b0;
            convert_start_ff <= 1'b0;
            idx_ff           <= 7'h00;
            acc_ff           <= 16'h0000;
        end else begin
            convert_start_ff <= 1'b0;
            case (state_ff)
                adcc_pkg::ST_IDLE: begin
                    cnt_ff <= 9'h000;
                    if (start_req) begin
                        busy_ff  <= 1'b1;
                        state_ff <= (init_pend_ff && init_cyc != 9'h000) ? adcc_pkg::ST_INIT
                                                                         : adcc_pkg::ST_SAMPLE;
                    end
                end
                adcc_pkg::ST_INIT: begin
                    if (tick) begin
                        cnt_ff <= cnt_ff + 9'h001;
                        if (cnt_ff == init_cyc - 9'h001) begin
                            cnt_ff   <= 9'h000;
                            state_ff <= adcc_pkg::ST_SAMPLE;
                        end
                    end
                end
                adcc_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        cnt_ff <= cnt_ff + 9'h001;
                        if (cnt_ff == {3'h0, samp_len} - 9'h001) begin
                            cnt_ff           <= 9'h000;
                            convert_start_ff <= 1'b1;
                            state_ff         <= adcc_pkg::ST_CONVERT;
                        end
                    end
                end
                adcc_pkg::ST_CONVERT: begin
                    if (smp_done) begin
                        cnt_ff <= 9'h000;
                        // pause decided in GAP on the stepped field value
                        state_ff <= adcc_pkg::ST_GAP;
                        if (conv_last) begin
                            idx_ff  <= 7'h00;
                            acc_ff  <= 16'h0000;
                            busy_ff <= 1'b0;
                            if (!main_ff[adcc_pkg::BIT_FREE]) state_ff <= adcc_pkg::ST_IDLE;
                        end else begin
                            idx_ff <= idx_ff + 7'h01;
                            acc_ff <= nxt_acc;
                        end
                    end
                end
                adcc_pkg::ST_GAP: begin
                    // pause length, zero field skips it, >= survives a shrinking field
                    if (delay_ff[3:0] == 4'h0) begin
                        state_ff <= adcc_pkg::ST_SAMPLE;
                    end else if (tick) begin
                        cnt_ff <= cnt_ff + 9'h001;
                        if (cnt_ff >= {5'h00, delay_ff[3:0]} - 9'h001) begin
                            cnt_ff   <= 9'h000;
                            state_ff <= adcc_pkg::ST_SAMPLE;
                        end
                    end
                end
                default: state_ff <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    assign sample_switch_closed = (state_ff == adcc_pkg::ST_SAMPLE);
    assign convert_start        = convert_start_ff;

    ////////////////////////////////////////////////////////////////////////////
    // window decision on the full sum
    always_comb begin
        case (win_ff[2:0])
            adcc_pkg::WIN_BELOW:   win_hit = nxt_acc < wlt_ff;
            adcc_pkg::WIN_ABOVE:   win_hit = nxt_acc > wht_ff;
            adcc_pkg::WIN_INSIDE:  win_hit = (nxt_acc > wlt_ff) && (nxt_acc < wht_ff);
            adcc_pkg::WIN_OUTSIDE: win_hit = (nxt_acc < wlt_ff) || (nxt_acc > wht_ff);
            default:               win_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            result_ff <= 16'h0000;
        end else if (conv_last) begin
            result_ff <= nxt_acc;
        end
    end

    assign rdy_clr = (wr_flags && reg_wdata[adcc_pkg::BIT_RDY])
                     || (reg_rd && reg_addr == adcc_pkg::ADDR_RES_LO);
    assign win_clr = (wr_flags && reg_wdata[adcc_pkg::BIT_WIN])
                     || (reg_rd && reg_addr == adcc_pkg::ADDR_RES_LO);

    // Set wins over clear so a result landing on a clear is not missed
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_ff  <= 1'b0;
            winf_ff <= 1'b0;
        end else begin
            if (conv_last) rdy_ff <= 1'b1;
            else if (rdy_clr) rdy_ff <= 1'b0;
            if (conv_last && win_hit) winf_ff <= 1'b1;
            else if (win_clr) winf_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, unmapped offsets read zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else if (!reg_rd) begin
            rdata_ff <= 8'h00;
        end else if (reg_addr == adcc_pkg::ADDR_MAIN) begin
            rdata_ff <= main_ff;
        end else if (reg_addr == adcc_pkg::ADDR_ACC) begin
            rdata_ff <= acc_ctl_ff;
        end else if (reg_addr == adcc_pkg::ADDR_REFCLK) begin
            rdata_ff <= refclk_ff;
        end else if (reg_addr == adcc_pkg::ADDR_DELAY) begin
            rdata_ff <= delay_ff;
        end else if (reg_addr == adcc_pkg::ADDR_WIN) begin
            rdata_ff <= win_ff;
        end else if (reg_addr == adcc_pkg::ADDR_SAMP) begin
            rdata_ff <= samp_ff;
        end else if (reg_addr == adcc_pkg::ADDR_CMD) begin
            rdata_ff <= {7'h00, busy_ff};
        end else if (reg_addr == adcc_pkg::ADDR_FLAGS) begin
            rdata_ff <= {6'h00, winf_ff, rdy_ff};
        end else if (reg_addr == adcc_pkg::ADDR_RES_LO) begin
            rdata_ff <= result_ff[7:0];
        end else if (reg_addr == adcc_pkg::ADDR_RES_HI) begin
            rdata_ff <= result_ff[15:8];
        end else if (reg_addr == adcc_pkg::ADDR_WLT_LO) begin
            rdata_ff <= wlt_ff[7:0];
        end else if (reg_addr == adcc_pkg::ADDR_WLT_HI) begin
            rdata_ff <= wlt_ff[15:8];
        end else if (reg_addr == adcc_pkg::ADDR_WHT_LO) begin
            rdata_ff <= wht_ff[7:0];
        end else if (reg_addr == adcc_pkg::ADDR_WHT_HI) begin
            rdata_ff <= wht_ff[15:8];
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_busy_self_clear: assert property (conv_last |=> !busy_ff)
        else $error("start bit still set after completion");
    chk_ready_on_done: assert property (conv_last |=> rdy_ff)
        else $error("result ready not set at completion");
    chk_ready_w1c: assert property ((rdy_clr && !conv_last) |=> !rdy_ff)
        else $error("result ready not cleared");
    chk_gap_switch_open: assert property (state_ff == adcc_pkg::ST_GAP
                                          |-> !sample_switch_closed)
        else $error("sampling switch closed in pause");
    chk_disable_idle: assert property (!main_ff[adcc_pkg::BIT_EN]
                                       |=> state_ff == adcc_pkg::ST_IDLE && !busy_ff)
        else $error("sequencer active while disabled");
    chk_delay_wrap: assert property ((smp_done && !wr_delay && delay_ff[adcc_pkg::BIT_SAMPLE_DELAY_VARY]
                                      && delay_ff[3:0] == 4'hF) |=> delay_ff[3:0] == 4'h0)
        else $error("inter-sample delay did not wrap");
    chk_trunc_8bit: assert property ((conv_last && main_ff[adcc_pkg::BIT_RES]
                                      && acc_ctl_ff[2:0] == 3'h0)
                                     |=> result_ff[15:8] == 8'h00)
        else $error("low result bits not dropped");
    chk_result_bound: assert property (result_ff <= adcc_pkg::ACC_LIMIT)
        else $error("accumulated result above limit");
    chk_free_restart: assert property ((conv_last && main_ff[adcc_pkg::BIT_FREE]
                                        && main_ff[adcc_pkg::BIT_EN])
                                       |=> state_ff != adcc_pkg::ST_IDLE)
        else $error("continuous mode stopped");
    chk_window_code: assert property ($rose(winf_ff) |-> $past(win_ff[2:0]) != 3'h0
                                      && $past(win_ff[2:0]) <= adcc_pkg::WIN_OUTSIDE)
        else $error("window flag raised by unused code");
    cov_free_run: cover property (conv_last && main_ff[adcc_pkg::BIT_FREE] ##[1:1000] conv_last);
    cov_acc_64: cover property (conv_last && acc_ctl_ff[2:0] == adcc_pkg::ACC_MAX);
    cov_window_hit: cover property (conv_last && win_hit);
endmodule

/* File: adcc_core_model.sv */
// Purpose: behavioural analog core that answers each convert request
// Assumes: one request at a time, latency lat >= 1 cycles
// Notes:   result shows the inverse value when idle, so a stale read is caught
module adcc_core_model (
    // Clock and request
    input  wire logic       mclk,
    input  wire logic       convert_start,
    input  wire logic [2:0] lat,
    input  wire logic [9:0] value,
    // Answer
    output logic            core_done,
    output logic [9:0]      core_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_ff = 3'h0;
    always_ff @(posedge mclk)
        cnt_ff <= convert_start ? lat : cnt_ff - {2'h0, cnt_ff != 3'h0};
    assign core_done   = cnt_ff == 3'h1;
    assign core_result = core_done ? value : ~value;
endmodule

/* File: adcc_top_tb_top.sv */
// Purpose: self-checking bench of the converter control block
// Assumes: core model answers each convert request; sleep raised only once, in the final standby check
// Notes:   random values from an LFSR with a fixed start
module adcc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_b, reg_wr, reg_rd, core_done, sw, cst, cap;
    logic        stby, wake, cen;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
    logic [9:0]  core_result, val;
    logic [2:0]  lat, ac;
    logic [1:0]  refs;
    logic [15:0] s;
    logic [31:0] lf = 32'h978BE659;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [7:0]  msk [6] = '{8'h87, 8'h07, 8'h77, 8'hFF, 8'h07, 8'h1F};
    adcc_top dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .standby_sleep(stby), .deep_wake(wake), .core_done, .core_result,
        .core_enable(cen), .sample_switch_closed(sw), .convert_start(cst),
        .reference_select(refs), .sample_cap_select(cap));
    adcc_core_model core (.mclk, .convert_start(cst), .lat, .value(val), .core_done,
        .core_result);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Samples per result; the reserved count takes a single sample
    function automatic int n_of(input logic [2:0] c);
        return (c == 3'h7) ? 1 : 1 << c;
    endfunction
    function automatic logic [15:0] sum_exp(input logic [9:0] v, input logic b8,
                                            input logic [2:0] c);
        logic [15:0] one;
        one = b8 ? {8'h00, v[9:2]} : {6'h00, v};
        return 16'(one * n_of(c));
    endfunction
    function automatic logic hit(input logic [15:0] x, input int m);
        case (m)
            1: return x < 16'h0100;
            2: return x > 16'h0300;
            3: return x > 16'h0100 && x < 16'h0300;
            4: return x < 16'h0100 || x > 16'h0300;
            default: return 1'b0;
        endcase
    endfunction
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Let an edge pass so a following write never re-raises the strobe in this step
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        @(posedge mclk);
    endtask
    // Bounded poll of bit 0; running out counts as a mismatch
    task automatic poll(input logic [7:0] a, input logic b);
        for (int k = 0; k < 10000; k++) begin
            rd(a);
            if (rv[0] === b) return;
        end
        check(rv[0], b);
        summarize();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, val, lat, stby, wake} = '0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 6; a++) begin
            rd(a[7:0]);
            check(rv, 8'h00);
            lf = nx(lf);
            wr(a[7:0], lf[7:0]);
            rd(a[7:0]);
            check(rv, lf[7:0] & msk[a]);
            if (a == 2) check({refs, cap}, {(&lf[5:4]) ? 2'h0 : lf[5:4], lf[6]});
        end
        wr(8'h07, 8'hFF);
        rd(8'h07);
        check(rv, 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h01);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h03);
        for (int i = 0; i < 12; i++) begin
            lf = nx(lf);
            val <= lf[9:0];
            lat <= lf[10] ? 3'h7 : 3'h1;
            // Two hand-picked corners: reserved count, then the longest sum
            ac = (i == 10) ? 3'h7 : (i == 11) ? 3'h6 : {1'b0, lf[12:11]};
            wr(8'h01, {5'h00, ac});
            wr(8'h02, {2'h0, lf[29:28], 3'h0, lf[13]});
            wr(8'h03, {lf[27:25], lf[18:14]});
            wr(8'h04, 8'(i % 8));
            wr(8'h05, {3'h0, lf[23:19]});
            wr(8'h00, {5'h00, lf[24], 2'h1});
            wr(8'h08, 8'h01);
            rd(8'h08);
            check(rv, 8'h01);
            poll(8'h08, 1'b0);
            check(sw, 1'b0);
            s = sum_exp(val, lf[24], ac);
            rd(8'h0B);
            check(rv, {6'h00, hit(s, i % 8), 1'b1});
            rd(8'h11);
            check(rv, s[15:8]);
            rd(8'h10);
            check(rv, s[7:0]);
            rd(8'h0B);
            check(rv, 8'h00);
            rd(8'h03);
            check(rv, {lf[27:25], lf[18], lf[17:14] + (lf[18] ? 4'(n_of(ac)) : 4'h0)});
            wr(8'h00, 8'h00);
        end
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h03);
        check(cen, 1'b1);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        wr(8'h08, 8'h01);
        poll(8'h0B, 1'b1);
        rd(8'h10);
        check(rv, val[7:0]);
        // No second start: a new result proves the continuous restart
        poll(8'h0B, 1'b1);
        rd(8'h11);
        check(rv, {6'h00, val[9:8]});
        wr(8'h00, 8'h01);
        stby <= 1'b1;
        @(posedge mclk);
        check(cen, 1'b0);
        wr(8'h00, 8'h81);
        check(cen, 1'b1);
        stby <= 1'b0;
        summarize();
    end
endmodule
